// ===== hdl/uipl_pkg.sv
package uipl_pkg;

	// register addresses on the local register port
	localparam logic [3:0] ADDR_MASK  = 4'h1;
	localparam logic [3:0] ADDR_CAUSE = 4'h2;

	// interrupt_mask_reg field positions
	localparam int MASK_RXD   = 0;
	localparam int MASK_TX    = 1;
	localparam int MASK_LSR   = 2;
	localparam int MASK_MSR   = 3;
	localparam int MASK_RSVD  = 4;
	localparam int MASK_XCHAR = 5;
	localparam int MASK_FOUT  = 6;
	localparam int MASK_FIN   = 7;

	// reset value and writable bits (reserved bit 4 stays zero)
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MASK_WBITS = 8'hef;

	// line_state_reg bits that drive the transmit source
	localparam int LSR_THR_EMPTY = 5;
	localparam int LSR_TX_IDLE   = 6;

	// interrupt_cause_reg bits 5..0 per priority level
	localparam logic [5:0] CODE_LSR   = 6'h06;
	localparam logic [5:0] CODE_RXD   = 6'h04;
	localparam logic [5:0] CODE_RXTO  = 6'h0c;
	localparam logic [5:0] CODE_TX    = 6'h02;
	localparam logic [5:0] CODE_MSR   = 6'h00;
	localparam logic [5:0] CODE_XCHAR = 6'h10;
	localparam logic [5:0] CODE_FLOW  = 6'h20;
	localparam logic [5:0] CODE_NONE  = 6'h01;

	// interrupt_cause_reg bits 7..6
	localparam logic [1:0] FIFO_ON  = 2'h3;
	localparam logic [1:0] FIFO_OFF = 2'h0;

	// receive timeout: character times plus extra bit times
	localparam logic [7:0] TO_CHARS      = 8'h04;
	localparam logic [7:0] TO_EXTRA_BITS = 8'h0c;
	localparam int         TO_CNT_W      = 8;

	// reported priority level, one-hot
	typedef enum logic [7:0] {
		LVL_NONE  = 8'h01,
		LVL_LSR   = 8'h02,
		LVL_RXD   = 8'h04,
		LVL_RXTO  = 8'h08,
		LVL_TX    = 8'h10,
		LVL_MSR   = 8'h20,
		LVL_XCHAR = 8'h40,
		LVL_FLOW  = 8'h80
	} uipl_level_e;

endpackage

// ===== hdl/uipl_to_if.sv
`timescale 1ns/10ps
interface uipl_to_if;
	logic       bit_tick;
	logic [3:0] char_bits;
	logic       armed;
	logic       restart;
	logic       expired;

	modport ctrl (
		output bit_tick,
		output char_bits,
		output armed,
		output restart,
		input  expired
	);

	modport timer (
		input  bit_tick,
		input  char_bits,
		input  armed,
		input  restart,
		output expired
	);
endinterface

// ===== hdl/uipl_rxto.sv
`timescale 1ns/10ps
module uipl_rxto (
	input wire logic clk,
	input wire logic reset,
	uipl_to_if.timer to
);
	typedef struct packed {
		logic [uipl_pkg::TO_CNT_W-1:0] cnt;
		logic                          expired;
	} uipl_rxto_s;

	uipl_rxto_s                    st;
	uipl_rxto_s                    next_st;
	logic [uipl_pkg::TO_CNT_W-1:0] limit;

	// idle limit in bit times: four characters plus twelve bits
	assign limit = uipl_pkg::TO_CHARS * {4'h0, to.char_bits}
		+ uipl_pkg::TO_EXTRA_BITS;

	// count idle bit times; saturate so the timer fires only once
	always_comb begin
		next_st = st;
		next_st.expired = 1'b0;
		if (!to.armed || to.restart) begin
			next_st.cnt = 8'h00;
		end else if (to.bit_tick && st.cnt != limit) begin
			next_st.cnt = st.cnt + 8'h01;
			if (st.cnt == limit - 8'h01) begin
				next_st.expired = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign to.expired = st.expired;
endmodule

// ===== hdl/uipl_top.sv
// Contract
// R1 - receive data interrupt: character held, or FIFO level at trigger.
// R2 - FIFO mode timeout after four characters plus twelve bit times idle.
// R3 - without half duplex, transmit interrupt follows line state bit 5.
// R4 - with half duplex, transmit interrupt follows line state bit 6.
// R5 - line status interrupt at once on a character with error bits.
// R6 - mask bits 0..3 per source, bit 4 reserved, all reset zero.
// R7 - mask bits 5..7 act only with enhanced enable set.
// R8 - modem control bit 2 picks RTS/DTR output and CTS/DSR input.
// R9 - flow input rising edge interrupts when auto input flow enabled.
// R10 - flow output rising edge interrupts when auto output flow enabled.
// R11 - modem status interrupt when any delta bit sets.
// R12 - Xon, Xoff or special character raises received character interrupt.
// R13 - wake indicator set leaving sleep, cleared by global source read.
// R14 - cause read shows only the highest pending; others stay queued.
// R15 - codes for levels 1..4: 06, 04, 0c, 02.
// R16 - codes for levels 5..7 and none: 00, 10, 20, 01.
// R17 - cause bit 0 low while pending, high otherwise, resets high.
// R18 - line state read clears line status; modem read clears modem and flow.
// R19 - receive data clears below trigger; timeout clears when FIFO empty.
// R20 - cause read clears transmit and Xon/Xoff; special also by next char.
// R21 - cause bits 7..6 read ones with FIFOs on, zeros off.
// R22 - interrupt output high while any enabled source is pending.
`timescale 1ns/10ps
module uipl_top #(
	parameter int LEVEL_W = 7
) (
	input  wire logic               CLK_SYS,
	input  wire logic               RESET,
	input  wire logic [3:0]         ADDR,
	input  wire logic [7:0]         WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output      logic [7:0]         RDATA,
	input  wire logic               FIFO_EN,
	input  wire logic               AUTO_HALF_DUPLEX,
	input  wire logic               ENH_EN,
	input  wire logic               AUTO_IN_FLOW,
	input  wire logic               AUTO_OUT_FLOW,
	input  wire logic               PIN_SEL,
	input  wire logic               RHR_FULL,
	input  wire logic [LEVEL_W-1:0] RX_LEVEL,
	input  wire logic [LEVEL_W-1:0] RX_TRIG,
	input  wire logic               RX_CHAR_IN,
	input  wire logic [3:0]         RX_ERR,
	input  wire logic               RX_POP,
	input  wire logic               RX_ACTIVE,
	input  wire logic               BIT_TICK,
	input  wire logic [3:0]         CHAR_BITS,
	input  wire logic [7:0]         LINE_STATE,
	input  wire logic [3:0]         MODEM_DELTA,
	input  wire logic               XON_DET,
	input  wire logic               XOFF_DET,
	input  wire logic               SPECIAL_DET,
	input  wire logic               CTS_N,
	input  wire logic               DSR_N,
	input  wire logic               RTS_N,
	input  wire logic               DTR_N,
	input  wire logic               WAKE_EVENT,
	input  wire logic               LSR_READ,
	input  wire logic               MSR_READ,
	input  wire logic               GLOBAL_IRQ_SOURCE_0_READ,
	output      logic               IRQ,
	output      logic               WAKE_IND
);
	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] rdata;
		logic       irq;
		logic       wake;
		logic       lsr_p;
		logic       rxto_p;
		logic       tx_p;
		logic       msr_p;
		logic       xchar_p;
		logic       spec_p;
		logic       fin_p;
		logic       fout_p;
		logic       tx_src_q;
		logic       delta_q;
		logic       fin_pin_q;
		logic       fout_pin_q;
	} uipl_top_s;

	uipl_top_s            st;
	uipl_top_s            next_st;
	uipl_pkg::uipl_level_e level;
	logic [5:0]           code;
	logic                 en_rxd;
	logic                 en_tx;
	logic                 en_lsr;
	logic                 en_msr;
	logic                 en_x;
	logic                 en_fo;
	logic                 en_fi;
	logic                 rxd_lvl;
	logic                 tx_src;
	logic                 fin_pin;
	logic                 fout_pin;
	logic                 cause_rd;
	logic                 mask_wr;
	logic                 any_next;

	uipl_to_if to_bus ();

	// the timer only runs while the FIFO holds data below its trigger
	// and the line is quiet; any new character or pop restarts it
	// R2 - timeout arming
	assign to_bus.bit_tick  = BIT_TICK;
	assign to_bus.char_bits = CHAR_BITS;
	assign to_bus.armed     = FIFO_EN && RX_LEVEL != '0
		&& RX_LEVEL < RX_TRIG && !RX_ACTIVE;
	assign to_bus.restart   = RX_CHAR_IN || RX_POP;

	uipl_rxto u_rxto (
		.clk   (CLK_SYS),
		.reset (RESET),
		.to    (to_bus)
	);

	// per-source enables
	always_comb begin
		// R6 - base enables
		en_rxd = st.mask[uipl_pkg::MASK_RXD];
		en_tx  = st.mask[uipl_pkg::MASK_TX];
		en_lsr = st.mask[uipl_pkg::MASK_LSR];
		en_msr = st.mask[uipl_pkg::MASK_MSR];
		// R7 - enhanced enable gate
		en_x   = st.mask[uipl_pkg::MASK_XCHAR] && ENH_EN;
		en_fo  = st.mask[uipl_pkg::MASK_FOUT] && ENH_EN;
		en_fi  = st.mask[uipl_pkg::MASK_FIN] && ENH_EN;
	end

	// level sources and pin selection
	always_comb begin
		// R1 - receive data level
		rxd_lvl = FIFO_EN ? (RX_LEVEL >= RX_TRIG) : RHR_FULL;
		// R3 - normal transmit source
		tx_src  = LINE_STATE[uipl_pkg::LSR_THR_EMPTY];
		if (AUTO_HALF_DUPLEX) begin
			// R4 - half duplex source
			tx_src = LINE_STATE[uipl_pkg::LSR_TX_IDLE];
		end
		// R8 - pin select
		fin_pin  = PIN_SEL ? DSR_N : CTS_N;
		fout_pin = PIN_SEL ? DTR_N : RTS_N;
	end

	// fixed priority: earlier branch is the higher level
	always_comb begin
		// R14 - highest pending only
		if (st.lsr_p && en_lsr) begin
			level = uipl_pkg::LVL_LSR;
		end else if (rxd_lvl && en_rxd) begin
			level = uipl_pkg::LVL_RXD;
		end else if (st.rxto_p && en_rxd) begin
			level = uipl_pkg::LVL_RXTO;
		end else if (st.tx_p && en_tx) begin
			level = uipl_pkg::LVL_TX;
		end else if (st.msr_p && en_msr) begin
			level = uipl_pkg::LVL_MSR;
		end else if ((st.xchar_p || st.spec_p) && en_x) begin
			level = uipl_pkg::LVL_XCHAR;
		end else if ((st.fin_p && en_fi) || (st.fout_p && en_fo)) begin
			level = uipl_pkg::LVL_FLOW;
		end else begin
			level = uipl_pkg::LVL_NONE;
		end
	end

	// cause code for the reported level
	always_comb begin
		case (level)
			// R15 - levels 1 to 4
			uipl_pkg::LVL_LSR: begin
				code = uipl_pkg::CODE_LSR;
			end
			uipl_pkg::LVL_RXD: begin
				code = uipl_pkg::CODE_RXD;
			end
			uipl_pkg::LVL_RXTO: begin
				code = uipl_pkg::CODE_RXTO;
			end
			uipl_pkg::LVL_TX: begin
				code = uipl_pkg::CODE_TX;
			end
			// R16 - levels 5 to 7
			uipl_pkg::LVL_MSR: begin
				code = uipl_pkg::CODE_MSR;
			end
			uipl_pkg::LVL_XCHAR: begin
				code = uipl_pkg::CODE_XCHAR;
			end
			uipl_pkg::LVL_FLOW: begin
				code = uipl_pkg::CODE_FLOW;
			end
			// R17 - bit 0 high when idle
			default: begin
				code = uipl_pkg::CODE_NONE;
			end
		endcase
	end

	// register port decode
	assign cause_rd = RD && ADDR == uipl_pkg::ADDR_CAUSE;
	assign mask_wr  = WR && ADDR == uipl_pkg::ADDR_MASK;

	// next state; every sticky flag lets a new event win over its clear
	always_comb begin
		next_st = st;
		next_st.tx_src_q   = tx_src;
		next_st.delta_q    = |MODEM_DELTA;
		next_st.fin_pin_q  = fin_pin;
		next_st.fout_pin_q = fout_pin;

		// R6 - mask write, reserved bit held zero
		if (mask_wr) begin
			next_st.mask = WDATA & uipl_pkg::MASK_WBITS;
		end

		// read data stand only in the cycle after the strobe
		next_st.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				uipl_pkg::ADDR_MASK: begin
					next_st.rdata = st.mask;
				end
				uipl_pkg::ADDR_CAUSE: begin
					// R21 - FIFO status bits
					next_st.rdata = {FIFO_EN ? uipl_pkg::FIFO_ON
						: uipl_pkg::FIFO_OFF, code};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// R5 - error on arriving character
		next_st.lsr_p = (RX_CHAR_IN && |RX_ERR)
			// R18 - line state read clears
			|| (st.lsr_p && !LSR_READ);

		// R19 - timeout holds until FIFO empty
		next_st.rxto_p = to_bus.expired
			|| (st.rxto_p && RX_LEVEL != '0);

		// a cause read clears a source only if it was the one shown,
		// so a lower level stays queued for the next read
		// R20 - transmit cleared by cause read
		next_st.tx_p = (tx_src && !st.tx_src_q)
			|| (st.tx_p && !(cause_rd && level == uipl_pkg::LVL_TX));

		// R11 - any delta bit sets
		next_st.msr_p = (|MODEM_DELTA && !st.delta_q)
			|| (st.msr_p && !MSR_READ);

		// R12 - received character detect
		next_st.xchar_p = XON_DET || XOFF_DET
			// R20 - Xon/Xoff cleared by cause read
			|| (st.xchar_p
			&& !(cause_rd && level == uipl_pkg::LVL_XCHAR));
		next_st.spec_p = SPECIAL_DET
			// R20 - special also cleared by next char
			|| (st.spec_p && !RX_CHAR_IN
			&& !(cause_rd && level == uipl_pkg::LVL_XCHAR));

		// R9 - flow input low to high
		next_st.fin_p = (AUTO_IN_FLOW && fin_pin && !st.fin_pin_q)
			// R18 - modem read clears flow
			|| (st.fin_p && !MSR_READ);
		// R10 - flow output low to high
		next_st.fout_p = (AUTO_OUT_FLOW && fout_pin && !st.fout_pin_q)
			|| (st.fout_p && !MSR_READ);

		// R13 - wake indicator
		next_st.wake = WAKE_EVENT || (st.wake && !GLOBAL_IRQ_SOURCE_0_READ);
	end

	// interrupt output tracks the flags being loaded this edge, so it
	// is not a cycle behind them; receive data is a live level input
	always_comb begin
		// R22 - any enabled pending source
		any_next = (next_st.lsr_p && en_lsr)
			|| (rxd_lvl && en_rxd)
			|| (next_st.rxto_p && en_rxd)
			|| (next_st.tx_p && en_tx)
			|| (next_st.msr_p && en_msr)
			|| ((next_st.xchar_p || next_st.spec_p) && en_x)
			|| (next_st.fin_p && en_fi)
			|| (next_st.fout_p && en_fo)
			|| next_st.wake;
	end

	// single state register
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			st <= '0;
			st.mask <= uipl_pkg::MASK_RESET;
		end else begin
			st <= next_st;
			st.irq <= any_next;
		end
	end

	// outputs straight from flip-flops
	assign RDATA    = st.rdata;
	assign IRQ      = st.irq;
	assign WAKE_IND = st.wake;
endmodule

// ===== verif/uipl_host.sv
`timescale 1ns/10ps
// register port master standing in for host software
module uipl_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output      logic [3:0] addr,
	output      logic [7:0] wdata,
	output      logic       wr,
	output      logic       rd
);
	// quiet bus from time zero
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one-cycle write strobe beside address and data
	task automatic write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe edge
	task automatic read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
endmodule

// ===== verif/uipl_chk.sv
`timescale 1ns/10ps
module uipl_chk (
	input wire logic       CLK_SYS,
	input wire logic       RESET,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       FIFO_EN,
	input wire logic       RX_CHAR_IN,
	input wire logic [3:0] RX_ERR,
	input wire logic       LSR_READ,
	input wire logic       WAKE_EVENT,
	input wire logic       GLOBAL_IRQ_SOURCE_0_READ,
	input wire logic       IRQ,
	input wire logic       WAKE_IND
);
	logic [7:0] mask;
	logic       rdc;
	// mirror of the mask register, reserved bit never sticks
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			mask <= 8'h00;
		else if (WR && ADDR == uipl_pkg::ADDR_MASK)
			mask <= WDATA & uipl_pkg::MASK_WBITS;
	end
	// data cycle of a read; reset kills stale strobes
	always_ff @(posedge CLK_SYS)
		rdc <= RD && !RESET;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	a_cause_fifo: assert property (rdc
		&& $past(ADDR) == uipl_pkg::ADDR_CAUSE
		|-> RDATA[7:6] == {2{$past(FIFO_EN)}})
		else $error("cause bits 7:6 wrong");
	a_none_bit: assert property (rdc
		&& $past(ADDR) == uipl_pkg::ADDR_CAUSE
		|-> RDATA[0] == (RDATA[5:0] == uipl_pkg::CODE_NONE))
		else $error("cause bit 0 wrong");
	a_mask_read: assert property (rdc
		&& $past(ADDR) == uipl_pkg::ADDR_MASK |-> RDATA == mask)
		else $error("mask readback wrong");
	a_lsr_irq: assert property (RX_CHAR_IN && RX_ERR != 4'h0
		&& mask[uipl_pkg::MASK_LSR] |=> IRQ)
		else $error("error character gave no interrupt");
	a_lsr_first: assert property (RX_CHAR_IN && !WR
		&& RX_ERR != 4'h0 && mask[uipl_pkg::MASK_LSR]
		##1 !LSR_READ && !WR
		##1 RD && !LSR_READ && ADDR == uipl_pkg::ADDR_CAUSE
		|=> RDATA[5:0] == uipl_pkg::CODE_LSR)
		else $error("line status not reported first");
	a_irq_quiet: assert property (mask == 8'h00 && $stable(mask)
		&& !WAKE_IND |-> !IRQ)
		else $error("interrupt with all sources masked");
	a_wake_set: assert property (WAKE_EVENT |=> WAKE_IND && IRQ)
		else $error("wake not indicated");
	a_wake_clr: assert property (GLOBAL_IRQ_SOURCE_0_READ && !WAKE_EVENT
		|=> !WAKE_IND)
		else $error("wake indicator not cleared");
	cover property (rdc && RDATA[5:0] == uipl_pkg::CODE_RXTO);
	cover property (rdc && RDATA[5:0] == uipl_pkg::CODE_FLOW);
	cover property (WAKE_EVENT ##[1:8] GLOBAL_IRQ_SOURCE_0_READ);
endmodule
bind uipl_top uipl_chk u_chk (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .FIFO_EN(FIFO_EN),
	.RX_CHAR_IN(RX_CHAR_IN), .RX_ERR(RX_ERR), .LSR_READ(LSR_READ),
	.WAKE_EVENT(WAKE_EVENT), .GLOBAL_IRQ_SOURCE_0_READ(GLOBAL_IRQ_SOURCE_0_READ), .IRQ(IRQ),
	.WAKE_IND(WAKE_IND)
);

// ===== verif/test_uipl_top.sv
`timescale 1ns/10ps
module test_uipl_top;
	logic       clk = 1'b0, rst = 1'b1, fifo_en = 1'b0, ahd = 1'b0;
	logic       enh = 1'b0, ain = 1'b0, aout = 1'b0, psel = 1'b0;
	logic       rx_hold_reg = 1'b0, tick = 1'b0, cts_n = 1'b0, dsr_n = 1'b0;
	logic       rts_n = 1'b0, wr, rd, irq, wake;
	logic       dtr_n = 1'b0, act = 1'b0;
	logic [6:0] lvl = 7'h00, trig = 7'h08;
	logic [3:0] err = 4'h0, delta = 4'h0, addr;
	logic [7:0] ls = 8'h00, msk = 8'h00, rdata, rd_v, wdata;
	logic [8:0] ev = 9'h000;
	logic [8:1] pend = 8'h00;
	logic [5:0] code [9] = '{6'h01, 6'h06, 6'h04, 6'h0c, 6'h02, 6'h00,
		6'h10, 6'h20, 6'h20};
	int         miscompares = 0, tests_run = 0;
	uipl_top dut (
		.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .FIFO_EN(fifo_en), .AUTO_HALF_DUPLEX(ahd),
		.ENH_EN(enh), .AUTO_IN_FLOW(ain), .AUTO_OUT_FLOW(aout),
		.PIN_SEL(psel), .RHR_FULL(rx_hold_reg), .RX_LEVEL(lvl), .RX_TRIG(trig),
		.RX_CHAR_IN(ev[0]), .RX_ERR(err), .RX_POP(ev[1]),
		.RX_ACTIVE(act), .BIT_TICK(tick), .CHAR_BITS(4'ha),
		.LINE_STATE(ls), .MODEM_DELTA(delta), .XON_DET(ev[2]),
		.XOFF_DET(ev[3]), .SPECIAL_DET(ev[4]), .CTS_N(cts_n),
		.DSR_N(dsr_n), .RTS_N(rts_n), .DTR_N(dtr_n), .WAKE_EVENT(ev[5]),
		.LSR_READ(ev[6]), .MSR_READ(ev[7]), .GLOBAL_IRQ_SOURCE_0_READ(ev[8]),
		.IRQ(irq), .WAKE_IND(wake)
	);
	uipl_host host (
		.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd)
	);
	// 100 MHz clock
	initial forever #5 clk = ~clk;
	// enabled sources per level; 8 is the flow output pin
	function automatic logic [8:1] en();
		return {msk[6] & enh, msk[7] & enh, msk[5] & enh, msk[3], msk[1],
			msk[0], msk[0], msk[2]};
	endfunction
	// highest enabled pending level, 0 when none
	function automatic int top();
		logic [8:1] p;
		p = pend & en();
		for (int l = 1; l < 9; l++)
			if (p[l])
				return l;
		return 0;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle event pulse; #1 lets the edge's updates land
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		#1;
	endtask
	// cause read; a shown transmit or character level is consumed
	task automatic cause();
		int l;
		l = top();
		host.read(uipl_pkg::ADDR_CAUSE, rd_v);
		chk(rd_v, {fifo_en ? 2'b11 : 2'b00, code[l]});
		if (l == 4 || l == 6)
			pend[l] = 1'b0;
		chk({7'h00, irq}, {7'h00, top() != 0});
	endtask
	task automatic done(input string s);
		$display("test %s over", s);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		$display("unexpected at %0t: run too long", $time);
		end_sim();
	end
	initial begin
		void'($urandom(32'h81069c67));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		host.read(uipl_pkg::ADDR_MASK, rd_v);
		chk(rd_v, 8'h00);
		cause();
		host.write(uipl_pkg::ADDR_MASK, 8'h01);
		msk = 8'h01;
		@(posedge clk) rx_hold_reg <= 1'b1;
		pend[2] = 1'b1;
		cause();
		@(posedge clk) rx_hold_reg <= 1'b0;
		pend[2] = 1'b0;
		rd_v = 8'($urandom);
		host.write(uipl_pkg::ADDR_MASK, rd_v);
		msk = rd_v & 8'hef;
		host.read(uipl_pkg::ADDR_MASK, rd_v);
		chk(rd_v, msk);
		host.read(4'h7, rd_v);
		chk(rd_v, 8'h00);
		done("registers");
		@(posedge clk) begin
			fifo_en <= 1'b1;
			enh <= 1'b1;
			ain <= 1'b1;
			aout <= 1'b1;
		end
		host.write(uipl_pkg::ADDR_MASK, 8'hff);
		msk = 8'hef;
		@(posedge clk) delta <= 4'h1 << $urandom_range(3, 0);
		@(posedge clk) ls <= 8'h20;
		@(posedge clk) lvl <= 7'h08;
		@(posedge clk) cts_n <= 1'b1;
		@(posedge clk) err <= 4'($urandom_range(15, 1));
		pulse(2);
		pulse(0);
		pend = 8'h7b;
		cause();
		pulse(6);
		pend[1] = 1'b0;
		cause();
		@(posedge clk) lvl <= 7'h07;
		pend[2] = 1'b0;
		cause();
		cause();
		pulse(7);
		pend = 8'h20;
		cause();
		cause();
		done("priority");
		@(posedge clk) enh <= 1'b0;
		pulse(4);
		pend[6] = 1'b1;
		cause();
		@(posedge clk) enh <= 1'b1;
		for (int i = 2; i < 5; i++) begin
			pulse(i);
			pend[6] = 1'b1;
			cause();
		end
		@(posedge clk) err <= 4'h0;
		pulse(4);
		pulse(0);
		cause();
		done("characters");
		@(posedge clk) begin
			psel <= 1'b1;
			cts_n <= 1'b0;
		end
		@(posedge clk) cts_n <= 1'b1;
		cause();
		@(posedge clk) dsr_n <= 1'b1;
		pend[7] = 1'b1;
		cause();
		pulse(7);
		pend[7] = 1'b0;
		@(posedge clk) psel <= 1'b0;
		@(posedge clk) rts_n <= 1'b1;
		pend[8] = 1'b1;
		cause();
		pulse(7);
		pend[8] = 1'b0;
		cause();
		// output side through the other pin of the pair
		@(posedge clk) psel <= 1'b1;
		@(posedge clk) dtr_n <= 1'b1;
		pend[8] = 1'b1;
		cause();
		pulse(7);
		pend[8] = 1'b0;
		cause();
		done("flow pins");
		@(posedge clk) ls <= 8'h00;
		@(posedge clk) ahd <= 1'b1;
		@(posedge clk) ls <= 8'h20;
		cause();
		@(posedge clk) ls <= 8'h60;
		pend[4] = 1'b1;
		cause();
		done("half duplex");
		// a busy receiver keeps the timer from counting
		@(posedge clk) begin
			tick <= 1'b1;
			act <= 1'b1;
		end
		repeat (60) @(posedge clk);
		cause();
		@(posedge clk) act <= 1'b0;
		repeat (40) @(posedge clk);
		cause();
		repeat (20) @(posedge clk);
		pend[3] = 1'b1;
		cause();
		@(posedge clk) begin
			tick <= 1'b0;
			lvl <= 7'h00;
		end
		pend[3] = 1'b0;
		cause();
		done("timeout");
		pulse(5);
		chk({6'h00, wake, irq}, 8'h03);
		pulse(8);
		chk({6'h00, wake, irq}, 8'h00);
		done("wake");
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		msk = 8'h00;
		pend = 8'h00;
		host.read(uipl_pkg::ADDR_MASK, rd_v);
		chk(rd_v, 8'h00);
		cause();
		done("second reset");
		end_sim();
	end
endmodule
